// ===== rtl/scan_pkg.sv
// Constants of the memory scan unit
// ==========================================================================
// How it works
// - Writing reset strobe bit 7 clears settings, enable bit and status a cycle later.
// - With trigger enable low, reset strobe acts at once even while busy.
// - With trigger enable high, reset strobe is ignored while busy.
// - Trigger enable bit 1 set makes a failed comparison raise the interrupt.
// - Trigger enable clears only on system reset, never by the strobe.
// - Writing one to trigger enable takes effect only when not busy.
// - Writing one to enable bit 0 starts a check; bit stays one.
// - Writing zero to enable bit does nothing.
// - After a start-up scan the enable bit reads one.
// - Once the interrupt fired, the first control register ignores writes.
// - Settings register ignores writes while busy or after the interrupt.
// - Access mode field bits 5:4; only 0 (priority, CPU halted) is defined.
// - After start-up scan mode reads non-zero; software writes it back to 0.
// - Section field bits 1:0: 0 whole, 1 boot plus code, 2 boot, 3 reserved.
// - After a start-up scan, section field shows the section checked.
// - Pass flag status bit 1 resets to one; status resets to 0x02.
// - Busy flag status bit 0 is one during a scan; writes restricted.
// - CRC x^16+x^12+x^5+1, seed 0xffff, bytes fed msb first from byte 0.
// - Scan begins three cycles after enable is written; CPU runs until then and is halted during the scan.
// - Failure clears pass flag; interrupt request holds until system reset.
// - Last two section bytes hold expected checksum, high byte first.
package scan_pkg;
  localparam logic [1:0] ofs_control_primary  = 2'h0;
  localparam logic [1:0] ofs_control_settings = 2'h1;
  localparam logic [1:0] ofs_status           = 2'h2;
  localparam int         bit_reset_strobe     = 7;
  localparam int         bit_trigger_enable   = 1;
  localparam int         bit_enable           = 0;
  localparam int         bit_pass             = 1;
  localparam int         bit_busy             = 0;
  localparam int         mode_lsb             = 4;
  localparam int         section_lsb          = 0;
  localparam logic [1:0] mode_priority        = 2'h0;
  localparam logic [1:0] section_whole        = 2'h0;
  localparam logic [1:0] section_boot_code    = 2'h1;
  localparam logic [1:0] section_boot         = 2'h2;
  localparam logic [7:0] reset_control        = 8'h00;
  localparam logic [7:0] reset_status         = 8'h02;
  localparam logic [15:0] crc_seed            = 16'hffff;
  localparam logic [15:0] crc_poly            = 16'h1021;
  localparam int          start_delay_cycles  = 3;
endpackage : scan_pkg

// ===== rtl/crc16_byte.sv
// One byte step of the CCITT checksum, msb first
`timescale 1ns/1ps
`default_nettype none
module crc16_byte (
  // Current checksum and byte
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data_in,
  // Updated checksum
  output logic      [15:0] crc_out
);
  always_comb begin
    logic [15:0] c;
    c = crc_in;
    for (int i = 7; i >= 0; i--) begin
      if (c[15] ^ data_in[i]) begin
        c = {c[14:0], 1'b0} ^ scan_pkg::crc_poly;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    crc_out = c;
  end
endmodule : crc16_byte
`default_nettype wire

// ===== rtl/memory_scan_unit.sv
// Control, status and scan sequencer of the memory scan unit
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module memory_scan_unit #(
  parameter int addr_width = 12,
  parameter logic [11:0] whole_end     = 12'hfff,
  parameter logic [11:0] boot_code_end = 12'h7ff,
  parameter logic [11:0] boot_end      = 12'h1ff
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  // Register port
  input  wire logic [1:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic      [7:0]            reg_rdata,
  // Start-up scan, sampled while the start-up request is high
  input  wire logic                  startup_scan,
  input  wire logic [1:0]            startup_section,
  input  wire logic [1:0]            startup_mode,
  // Flash read port, data one cycle after request
  output logic                       flash_req,
  output logic      [addr_width-1:0] flash_addr,
  input  wire logic [7:0]            flash_data,
  // System side
  output logic                       cpu_stall,
  output logic                       nmi_request
);
  typedef enum {st_idle, st_wait, st_read, st_take} phase_type;

  typedef struct packed {
    logic [7:0]            rdata;
    logic                  enable;
    logic                  trigger_enable;
    logic [1:0]            mode;
    logic [1:0]            section;
    logic                  pass;
    logic                  busy;
    logic                  nmi;
    logic                  clear_pending;
    logic [1:0]            delay;
    logic [addr_width-1:0] addr;
    logic [addr_width-1:0] last;
    logic [15:0]           crc;
    logic [7:0]            high_byte;
    logic [1:0]            tail;
    phase_type             phase;
  } state_type;

  state_type   s;
  state_type   next_s;
  logic [15:0] crc_step;

  crc16_byte u_crc (
    .crc_in  (s.crc),
    .data_in (flash_data),
    .crc_out (crc_step)
  );

  function automatic logic [addr_width-1:0] section_end(input logic [1:0] sel);
    case (sel)
      scan_pkg::section_boot_code: section_end = boot_code_end;
      scan_pkg::section_boot:      section_end = boot_end;
      default:                     section_end = whole_end;
    endcase
  endfunction : section_end

  logic wr_primary;
  logic wr_settings;
  logic strobe_ok;
  assign wr_primary  = reg_write && reg_addr == scan_pkg::ofs_control_primary && !s.nmi;
  assign wr_settings = reg_write && reg_addr == scan_pkg::ofs_control_settings
                       && !s.busy && !s.nmi;
  assign strobe_ok   = wr_primary && reg_wdata[scan_pkg::bit_reset_strobe]
                       && (!s.trigger_enable || !s.busy);

  always_comb begin
    next_s = s;
    // ==========================================================================
    // Register reads
    case (reg_addr)
      scan_pkg::ofs_control_primary:
        next_s.rdata = {6'h00, s.trigger_enable, s.enable};
      scan_pkg::ofs_control_settings:
        next_s.rdata = {2'h0, s.mode, 2'h0, s.section};
      scan_pkg::ofs_status:
        next_s.rdata = {6'h00, s.pass, s.busy};
      default:
        next_s.rdata = 8'h00;
    endcase
    if (!reg_read) begin
      next_s.rdata = 8'h00;
    end
    // ==========================================================================
    // Control writes
    if (wr_primary && reg_wdata[scan_pkg::bit_trigger_enable] && !s.busy) begin
      next_s.trigger_enable = 1'b1;
    end
    if (wr_settings) begin
      next_s.mode    = reg_wdata[scan_pkg::mode_lsb +: 2];
      next_s.section = reg_wdata[scan_pkg::section_lsb +: 2];
    end
    // ==========================================================================
    // Scan sequencer
    case (s.phase)
      st_idle: begin
        // Zero writes fall through untouched
        if (wr_primary && reg_wdata[scan_pkg::bit_enable] && !strobe_ok) begin
          next_s.enable = 1'b1;
          next_s.busy   = 1'b1;
          next_s.delay  = 2'(scan_pkg::start_delay_cycles - 1);
          next_s.phase  = st_wait;
        end
      end
      st_wait: begin
        // Grace cycles before the CPU is halted
        if (s.delay == 2'h0) begin
          next_s.crc   = scan_pkg::crc_seed;
          next_s.addr  = '0;
          next_s.last  = section_end(s.section);
          next_s.tail  = 2'h0;
          next_s.phase = st_read;
        end else begin
          next_s.delay = s.delay - 2'h1;
        end
      end
      st_read: begin
        next_s.phase = st_take;
      end
      st_take: begin
        // Last two bytes are the stored checksum, high byte first
        if (s.addr + 2 > s.last) begin
          next_s.tail = s.tail + 2'h1;
          if (s.tail == 2'h0) begin
            next_s.high_byte = flash_data;
          end
        end else begin
          next_s.crc = crc_step;
        end
        if (s.addr == s.last) begin
          next_s.busy  = 1'b0;
          next_s.pass  = {s.high_byte, flash_data} == s.crc;
          next_s.phase = st_idle;
        end else begin
          next_s.addr  = s.addr + 1'b1;
          next_s.phase = st_read;
        end
      end
      default: next_s.phase = st_idle;
    endcase
    if (next_s.busy == 1'b0 && s.busy && !next_s.pass && s.trigger_enable) begin
      next_s.nmi = 1'b1;
    end
    // ==========================================================================
    // Own reset strobe, lands one cycle after the write
    next_s.clear_pending = strobe_ok;
    if (s.clear_pending) begin
      next_s.enable  = 1'b0;
      next_s.mode    = 2'h0;
      next_s.section = 2'h0;
      next_s.busy    = 1'b0;
      next_s.pass    = scan_pkg::reset_status[scan_pkg::bit_pass];
      next_s.phase   = st_idle;
    end
    // Start-up scan result shows in read-back
    if (startup_scan) begin
      next_s.enable  = 1'b1;
      next_s.section = startup_section;
      next_s.mode    = startup_mode;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s                <= '0;
      s.pass           <= 1'b1;
      s.phase          <= st_idle;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata   = s.rdata;
  assign flash_req   = s.phase == st_read;
  assign flash_addr  = s.addr;
  assign cpu_stall   = s.phase == st_read || s.phase == st_take;
  assign nmi_request = s.nmi;

  // ==========================================================================
  // Checks
  sequence start_write;
    wr_primary && reg_wdata[0] && !strobe_ok && s.phase == st_idle;
  endsequence
  sequence grace_run;
    !cpu_stall [*3];
  endsequence

  a_start_delay: assert property (@(posedge clk_sys) disable iff (!resetn)
    start_write |=> grace_run ##0 1'b1 ##1 flash_req)
    else $error("scan did not start three cycles after enable");
  a_strobe_clears: assert property (@(posedge clk_sys) disable iff (!resetn)
    strobe_ok |=> ##1 (!s.busy && s.pass && !s.enable && s.section == 2'h0))
    else $error("reset strobe did not clear registers");
  // Watches the registered pending flag, not the gate that feeds it
  a_strobe_blocked: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wr_primary && reg_wdata[7] && s.trigger_enable && s.busy) |=> !s.clear_pending)
    else $error("strobe accepted while busy with trigger enable");
  a_trigger_sticky: assert property (@(posedge clk_sys) disable iff (!resetn)
    s.trigger_enable |=> s.trigger_enable)
    else $error("trigger enable dropped without system reset");
  a_nmi_holds: assert property (@(posedge clk_sys) disable iff (!resetn)
    nmi_request |=> nmi_request && !s.pass)
    else $error("interrupt request released");
  a_settings_locked: assert property (@(posedge clk_sys) disable iff (!resetn)
    (reg_write && reg_addr == 2'h1 && (s.busy || s.nmi) && !s.clear_pending && !startup_scan)
    |=> $stable(s.section))
    else $error("settings changed while locked");
  a_enable_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s.enable && !s.clear_pending && !startup_scan) |=> s.enable)
    else $error("enable bit cleared by write");
  a_busy_stall: assert property (@(posedge clk_sys) disable iff (!resetn)
    cpu_stall |-> s.busy)
    else $error("cpu stalled while idle");

  // ==========================================================================
  // Byte fetch sequence
  sequence byte_fetch;
    flash_req ##1 (s.phase == st_take && !flash_req);
  endsequence
  sequence last_take;
    s.phase == st_take && s.addr == s.last && !s.clear_pending;
  endsequence

  a_fetch_step: assert property (@(posedge clk_sys) disable iff (!resetn)
    (flash_req && s.addr < s.last && !strobe_ok && !s.clear_pending)
    |-> byte_fetch ##1 (flash_req && flash_addr == $past(flash_addr, 2) + 1'b1))
    else $error("byte fetch did not step to the next address");
  a_done_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
    last_take |=> (!s.busy && s.phase == st_idle && !cpu_stall))
    else $error("busy held after the last byte");
  a_nmi_on_fail: assert property (@(posedge clk_sys) disable iff (!resetn)
    (last_take ##0 (s.trigger_enable && {s.high_byte, flash_data} != s.crc))
    |=> nmi_request)
    else $error("failed comparison raised no interrupt");
  // A start while bytes are being fetched must not restart the grace count
  a_start_refused: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wr_primary && reg_wdata[0] && (s.phase == st_read || s.phase == st_take)
     && !s.clear_pending) |=> s.phase != st_wait)
    else $error("scan restarted while busy");
endmodule : memory_scan_unit
`default_nettype wire

// ===== tb/flash_model.sv
// Behavioural program memory answering the scan unit's byte reads
`timescale 1ns/1ps
`default_nettype none
module flash_model (
  // Clock
  input  wire logic        clk_sys,
  // Read port
  input  wire logic        flash_req,
  input  wire logic [11:0] flash_addr,
  output logic      [7:0]  flash_data
);
  logic [7:0] mem [0:4095];
  initial flash_data = 8'h00;
  // Outside a request the byte toggles, so a late sample never sees held data
  always @(posedge clk_sys) begin
    flash_data <= flash_req ? mem[flash_addr] : ~flash_data;
  end
endmodule : flash_model
`default_nettype wire

// ===== tb/memory_scan_unit_tb.sv
// Self-checking bench of the memory scan unit
`timescale 1ns/1ps
`default_nettype none
module memory_scan_unit_tb;
  // ==========================================================================
  // Wiring
  logic        clk_sys         = 1'b0;
  logic        resetn          = 1'b0;
  logic [1:0]  reg_addr        = 2'h0;
  logic [7:0]  reg_wdata       = 8'h00;
  logic        reg_write       = 1'b0;
  logic        reg_read        = 1'b0;
  logic        startup_scan    = 1'b0;
  logic [1:0]  startup_section = 2'h0;
  logic [1:0]  startup_mode    = 2'h0;
  logic [7:0]  reg_rdata;
  logic        flash_req;
  logic [11:0] flash_addr;
  logic [7:0]  flash_data;
  logic        cpu_stall;
  logic        nmi_request;
  logic [15:0] exp_q [$];
  logic        pend            = 1'b0;
  int          n_fail          = 0;
  int          n_checks        = 0;
  logic [11:0] ends [3]        = '{12'h01f, 12'h00f, 12'h007};
  always #50 clk_sys = ~clk_sys;
  // Short sections keep each scan to a few dozen cycles
  memory_scan_unit #(.whole_end(12'h01f), .boot_code_end(12'h00f), .boot_end(12'h007)) i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .startup_scan(startup_scan), .startup_section(startup_section),
    .startup_mode(startup_mode), .flash_req(flash_req), .flash_addr(flash_addr),
    .flash_data(flash_data), .cpu_stall(cpu_stall), .nmi_request(nmi_request));
  flash_model i_flash (.clk_sys(clk_sys), .flash_req(flash_req), .flash_addr(flash_addr),
    .flash_data(flash_data));
  // ==========================================================================
  // Tasks
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, want);
    end
  endtask : check
  task automatic bus(input logic w, input logic r, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= w;
    reg_read  <= r;
    reg_addr  <= a;
    reg_wdata <= d;
  endtask : bus
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] want, input logic [7:0] mask = 8'hff);
    bus(1'b0, 1'b1, a, 8'h00);
    exp_q.push_back({mask, want});
  endtask : rd
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, reg_addr, 8'h00);
  endtask : idle
  // Counts negedges until the stall reaches lvl; a run-out ends the test
  task automatic wait_stall(input logic lvl, input int lo);
    int k;
    k = 0;
    idle(1);
    do begin
      @(negedge clk_sys);
      k++;
    end while (cpu_stall !== lvl && k < 400);
    check({7'h00, k >= lo && k < 400}, 8'h01);
    if (k >= 400)
      give_verdict();
  endtask : wait_stall
  task automatic fill(input int s, input logic [7:0] bad);
    logic [15:0] c;
    c = scan_pkg::crc_seed;
    for (int i = 0; i < ends[s] - 1; i++) begin
      i_flash.mem[i] = 8'($urandom);
      for (int b = 7; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ i_flash.mem[i][b]) ? 16'h1021 : 16'h0000);
    end
    i_flash.mem[ends[s] - 1] = c[15:8];
    i_flash.mem[ends[s]]     = c[7:0] ^ bad;
  endtask : fill
  // ==========================================================================
  // Read data monitor: data stands only in the cycle after the strobe
  always @(negedge clk_sys) begin
    if (pend) begin
      check(reg_rdata & exp_q[0][15:8], exp_q[0][7:0]);
      exp_q.delete(0);
    end
    pend = reg_read;
  end
  // ==========================================================================
  // Scenarios
  initial begin
    void'($urandom(32'h94f1));
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int a = 0; a < 4; a++)
      rd(2'(a), a == 2 ? 8'h02 : 8'h00);
    for (int s = 0; s < 3; s++) begin
      fill(s, 8'h00);
      wr(2'h1, 8'(s));
      wr(2'h0, 8'h01);
      wait_stall(1'b1, 4);
      wait_stall(1'b0, 0);
      rd(2'h2, 8'h02);
      wr(2'h0, 8'h00);
      rd(2'h0, 8'h01);
    end
    fill(1, 8'h01);
    wr(2'h1, 8'h01);
    wr(2'h0, 8'h01);
    wait_stall(1'b1, 4);
    wait_stall(1'b0, 0);
    rd(2'h2, 8'h00);
    check({7'h00, nmi_request}, 8'h00);
    // Abort a running scan with the strobe
    wr(2'h1, 8'h02);
    wr(2'h0, 8'h01);
    wait_stall(1'b1, 4);
    rd(2'h2, 8'h01, 8'h01);
    wr(2'h1, 8'h00);
    wr(2'h0, 8'h03);
    rd(2'h1, 8'h02);
    rd(2'h0, 8'h01);
    wr(2'h0, 8'h80);
    idle(1);
    for (int a = 0; a < 3; a++)
      rd(2'(a), a == 2 ? 8'h02 : 8'h00);
    @(negedge clk_sys);
    check({7'h00, cpu_stall}, 8'h00);
    // Failure with the interrupt trigger armed
    wr(2'h0, 8'h02);
    wr(2'h0, 8'h80);
    rd(2'h0, 8'h02);
    fill(2, 8'h10);
    wr(2'h1, 8'h02);
    wr(2'h0, 8'h03);
    wait_stall(1'b1, 4);
    wr(2'h0, 8'h80);
    wait_stall(1'b0, 0);
    wr(2'h0, 8'h80);
    wr(2'h1, 8'h01);
    idle(4);
    rd(2'h0, 8'h03);
    rd(2'h1, 8'h02);
    rd(2'h2, 8'h00);
    @(negedge clk_sys);
    check({7'h00, nmi_request}, 8'h01);
    // Status read data latches at this edge, but reset clears it before the monitor checks it
    idle(1);
    // System reset with a start-up scan of the boot section
    fill(2, 8'h00);
    resetn          <= 1'b0;
    startup_scan    <= 1'b1;
    startup_section <= 2'h2;
    startup_mode    <= 2'h1;
    idle(2);
    resetn <= 1'b1;
    idle(2);
    startup_scan <= 1'b0;
    idle(4);
    wait_stall(1'b0, 0);
    check({7'h00, nmi_request}, 8'h00);
    rd(2'h0, 8'h01);
    rd(2'h1, 8'h12);
    wr(2'h1, 8'h02);
    rd(2'h1, 8'h02);
    idle(3);
    give_verdict();
  end
endmodule : memory_scan_unit_tb
`default_nettype wire
